// *** inc/lsb_params.svh ***
/*
 * constants for the led sink blink / dim register bank: offsets, fields,
 * reset values and blink timings.
 * assumes a 50 MHz sys_clk and 8-bit registers in 32-bit apb words.
 */
//
// Overview of operation
// - dim code bits 6:0 drive dimmed backlight
// - law 00 linear, 01 square, linear steps
// - law 10 and 11 square, nonlinear steps
// - enable bit 6 is sink 7, bit 0 sink 1
// - on time 0.2, 0.6, 0.8, 1.2 s
// - on time only when enabled, off nonzero
// - sinks 7..5 off time 0.6/1.2/1.8 s
// - blink on for on time, then off
// - cubic laws vary only time per step
`ifndef LSB_PARAMS_SVH
`define LSB_PARAMS_SVH

// ----------------------------------------
// register indexes; byte address is index times four
// ----------------------------------------
`define LSB_IDX_DIM        8'h0A
`define LSB_IDX_LAW        8'h0F
`define LSB_IDX_ENA        8'h10
`define LSB_IDX_TIME       8'h11
`define LSB_IDX_STATE      8'h20
`define LSB_ADDR_W         12

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define LSB_DIM_MSB        6
`define LSB_LAW_MSB        1
`define LSB_ENA_MSB        6
`define LSB_ON_LSB         6
`define LSB_NSINK          7
`define LSB_NBLINK         3
`define LSB_RST_VAL        8'h00

// ----------------------------------------
// timing: tick in ms, on/off times in ticks, cycles derived at 50 MHz
// ----------------------------------------
`define LSB_CLK_KHZ        50000
`define LSB_TICK_MS        200
`define LSB_TICK_CYC       (`LSB_TICK_MS * `LSB_CLK_KHZ)
`define LSB_ON_T0          3'd1
`define LSB_ON_T1          3'd3
`define LSB_ON_T2          3'd4
`define LSB_ON_T3          3'd6
`define LSB_OFF_T1         4'd3
`define LSB_OFF_T2         4'd6
`define LSB_OFF_T3         4'd9

`endif

// *** inc/lsb_pkg.sv ***
/*
 * types for the led sink register bank.
 * assumes lsb_params.svh is on the include path.
 */
package lsb_pkg;
	// ----------------------------------------
	// fade law codes
	// ----------------------------------------
	typedef enum logic [1:0] {
		LSB_LAW_LIN    = 2'h0,
		LSB_LAW_SQR    = 2'h1,
		LSB_LAW_CUB10  = 2'h2,
		LSB_LAW_CUB11  = 2'h3
	} lsb_law_t;

	// ----------------------------------------
	// blink phase, one-hot
	// ----------------------------------------
	typedef enum logic [2:0] {
		LSB_PH_IDLE = 3'b001,
		LSB_PH_ON   = 3'b010,
		LSB_PH_OFF  = 3'b100
	} lsb_phase_t;
endpackage : lsb_pkg

// *** rtl/lsb_tick.sv ***
/*
 * 200 ms tick generator: one-cycle pulse each tick period.
 * assumes sys_clk at 50 MHz; period parameter shortens simulation.
 */
`include "lsb_params.svh"

module lsb_tick
	import lsb_pkg::*;
#(
	parameter int unsigned TICK_CYC = `LSB_TICK_CYC
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rstn,
	input  wire logic clk_en,
	// tick out
	output logic      tick
);
	logic [23:0] cnt_q;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			cnt_q <= 24'h000000;
			tick  <= 1'b0;
		end else if (clk_en) begin
			tick <= (cnt_q == 24'(TICK_CYC - 1));
			if (cnt_q == 24'(TICK_CYC - 1)) begin
				cnt_q <= 24'h000000;
			end else begin
				cnt_q <= cnt_q + 24'h000001;
			end
		end
	end
endmodule : lsb_tick

// *** rtl/lsb_blink.sv ***
/*
 * one blinking sink: idle while disabled, on then off, repeating.
 * assumes a shared 200 ms tick pulse from the same clock.
 */
module lsb_blink
	import lsb_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       clk_en,
	// control
	input  wire logic       tick,
	input  wire logic       enable,
	input  wire logic [1:0] on_code,
	input  wire logic [1:0] off_code,
	// output
	output logic            lit
);
	`include "lsb_params.svh"

	lsb_phase_t phase_q;
	logic [3:0] cnt_q;

	function automatic logic [3:0] on_ticks(input logic [1:0] c);
		unique case (c)
			2'h0: on_ticks = {1'b0, `LSB_ON_T0};
			2'h1: on_ticks = {1'b0, `LSB_ON_T1};
			2'h2: on_ticks = {1'b0, `LSB_ON_T2};
			2'h3: on_ticks = {1'b0, `LSB_ON_T3};
		endcase
	endfunction : on_ticks

	function automatic logic [3:0] off_ticks(input logic [1:0] c);
		unique case (c)
			2'h0: off_ticks = 4'h0;
			2'h1: off_ticks = `LSB_OFF_T1;
			2'h2: off_ticks = `LSB_OFF_T2;
			2'h3: off_ticks = `LSB_OFF_T3;
		endcase
	endfunction : off_ticks

	// ----------------------------------------
	// phase machine; durations in whole ticks, first tick may be short
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			phase_q <= LSB_PH_IDLE;
			cnt_q   <= 4'h0;
		end else if (clk_en) begin
			unique case (phase_q)
				LSB_PH_IDLE: begin
					cnt_q <= 4'h0;
					if (enable) begin
						phase_q <= LSB_PH_ON;
					end
				end
				LSB_PH_ON: begin
					if (!enable) begin
						phase_q <= LSB_PH_IDLE;
					end else if (off_code == 2'h0) begin
						cnt_q <= 4'h0;
					end else if (tick) begin
						if (cnt_q + 4'h1 >= on_ticks(on_code)) begin
							phase_q <= LSB_PH_OFF;
							cnt_q   <= 4'h0;
						end else begin
							cnt_q <= cnt_q + 4'h1;
						end
					end
				end
				LSB_PH_OFF: begin
					if (!enable) begin
						phase_q <= LSB_PH_IDLE;
					end else if (off_code == 2'h0) begin
						phase_q <= LSB_PH_ON;
						cnt_q   <= 4'h0;
					end else if (tick) begin
						if (cnt_q + 4'h1 >= off_ticks(off_code)) begin
							phase_q <= LSB_PH_ON;
							cnt_q   <= 4'h0;
						end else begin
							cnt_q <= cnt_q + 4'h1;
						end
					end
				end
				default: begin
					phase_q <= LSB_PH_IDLE;
				end
			endcase
		end
	end

	always_comb begin
		lit = enable && (phase_q == LSB_PH_ON);
	end
endmodule : lsb_blink

// *** rtl/lsb_regs.sv ***
/*
 * led sink blink / dim register bank with apb slave.
 * assumes an apb master on sys_clk and a separate dim request from
 * the backlight timer logic, possibly on another clock.
 */
// The implementer's own choice: the APB register port.
`include "lsb_params.svh"

module lsb_regs
	import lsb_pkg::*;
#(
	parameter int unsigned TICK_CYC = `LSB_TICK_CYC
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        clk_en,
	// apb
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// backlight
	input  wire logic        dim_request,
	output logic      [6:0]  backlight_code,
	// independent sinks
	output logic      [6:0]  sink_on,
	output logic      [1:0]  sink_dac_law,
	output logic             sink_step_nonlinear,
	output logic      [1:0]  sink_fade_law_sel
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [6:0] backlight_dim_current_q;
	logic [1:0] sink_fade_law_q;
	logic [6:0] sink_enable_control_q;
	logic [7:0] sink_blink_time_upper_q;
	logic [6:0] lit;
	logic       tick;
	logic       dim_sync1_q;
	logic       dim_sync2_q;

	function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
		hit = (a == {2'h0, idx, 2'h0});
	endfunction : hit

	logic acc;
	logic known;
	always_comb begin
		acc   = psel && penable;
		known = hit(paddr, `LSB_IDX_DIM) || hit(paddr, `LSB_IDX_LAW)
			|| hit(paddr, `LSB_IDX_ENA) || hit(paddr, `LSB_IDX_TIME)
			|| hit(paddr, `LSB_IDX_STATE);
	end

	// ----------------------------------------
	// apb write side; reserved bits dropped
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			backlight_dim_current_q <= 7'(`LSB_RST_VAL);
			sink_fade_law_q         <= 2'(`LSB_RST_VAL);
			sink_enable_control_q   <= 7'(`LSB_RST_VAL);
			sink_blink_time_upper_q <= `LSB_RST_VAL;
		end else if (clk_en && acc && pwrite) begin
			if (hit(paddr, `LSB_IDX_DIM)) begin
				backlight_dim_current_q <= pwdata[`LSB_DIM_MSB:0];
			end
			if (hit(paddr, `LSB_IDX_LAW)) begin
				sink_fade_law_q <= pwdata[`LSB_LAW_MSB:0];
			end
			if (hit(paddr, `LSB_IDX_ENA)) begin
				sink_enable_control_q <= pwdata[`LSB_ENA_MSB:0];
			end
			if (hit(paddr, `LSB_IDX_TIME)) begin
				sink_blink_time_upper_q <= pwdata[7:0];
			end
		end
	end

	// ----------------------------------------
	// apb answer: zero wait, error on unmapped address
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !known;
			prdata  <= 32'h00000000;
			if (psel && !penable && !pwrite) begin
				if (hit(paddr, `LSB_IDX_DIM)) begin
					prdata <= {25'h0, backlight_dim_current_q};
				end else if (hit(paddr, `LSB_IDX_LAW)) begin
					prdata <= {30'h0, sink_fade_law_q};
				end else if (hit(paddr, `LSB_IDX_ENA)) begin
					prdata <= {25'h0, sink_enable_control_q};
				end else if (hit(paddr, `LSB_IDX_TIME)) begin
					prdata <= {24'h0, sink_blink_time_upper_q};
				end else if (hit(paddr, `LSB_IDX_STATE)) begin
					prdata <= {25'h0, lit};
				end
			end
		end
	end

	// ----------------------------------------
	// blink engines: sinks 7..5 blink, 4..1 have no off field here
	// ----------------------------------------
	lsb_tick #(
		.TICK_CYC (TICK_CYC)
	) u_tick (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.clk_en  (clk_en),
		.tick    (tick)
	);

	for (genvar i = 0; i < `LSB_NBLINK; i++) begin : g_blink
		lsb_blink u_blink (
			.sys_clk  (sys_clk),
			.rstn     (rstn),
			.clk_en   (clk_en),
			.tick     (tick),
			.enable   (sink_enable_control_q[4 + i]),
			.on_code  (sink_blink_time_upper_q[7:`LSB_ON_LSB]),
			.off_code (sink_blink_time_upper_q[2 * i + 1 -: 2]),
			.lit      (lit[4 + i])
		);
	end
	assign lit[3:0] = sink_enable_control_q[3:0];

	// ----------------------------------------
	// outputs; dim request may come from another domain, so synchronise
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			dim_sync1_q <= 1'b0;
			dim_sync2_q <= 1'b0;
		end else if (clk_en) begin
			dim_sync1_q <= dim_request;
			dim_sync2_q <= dim_sync1_q;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			backlight_code      <= 7'h00;
			sink_on             <= 7'h00;
			sink_dac_law        <= 2'h0;
			sink_step_nonlinear <= 1'b0;
			sink_fade_law_sel   <= 2'h0;
		end else if (clk_en) begin
			backlight_code <= dim_sync2_q ? backlight_dim_current_q : 7'h00;
			sink_on        <= lit;
			// dac law: 0 linear, 1 square; cubic codes reuse square dac
			sink_dac_law <= (sink_fade_law_q == LSB_LAW_LIN) ? 2'h0 : 2'h1;
			sink_step_nonlinear <= sink_fade_law_q[1];
			sink_fade_law_sel   <= sink_fade_law_q;
		end
	end
endmodule : lsb_regs

// *** verif/lsb_regs_monitor.sv ***
/* port checker for lsb_regs.
   bound to the top module by the bench; one clock, sync reset. */
module lsb_regs_monitor #(
	parameter int unsigned TICK_CYC = 20
) (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rstn,
	input wire logic        clk_en,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// sinks and backlight
	input wire logic        dim_request,
	input wire logic [6:0]  backlight_code,
	input wire logic [6:0]  sink_on,
	input wire logic [1:0]  sink_dac_law,
	input wire logic        sink_step_nonlinear,
	input wire logic [1:0]  sink_fade_law_sel
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_ready_setup: assert property (clk_en && psel && !penable |=> pready) else $error("no ready");
	a_ready_cause: assert property (pready |-> psel && penable) else $error("stray ready");
	a_ready_once: assert property (pready && clk_en |=> !pready) else $error("ready too long");
	a_err_pair: assert property (pslverr |-> pready) else $error("error without ready");
	a_err_read: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("bad read data");
	a_dim_rsvd: assert property (pready && !pwrite && paddr == 12'h028 |-> prdata[31:7] == 25'h0)
		else $error("dim reserved bits");
	a_law_rsvd: assert property (pready && !pwrite && paddr == 12'h03C |-> prdata[31:2] == 30'h0)
		else $error("law reserved bits");
	a_ena_rsvd: assert property (pready && !pwrite && paddr == 12'h040 |-> prdata[31:7] == 25'h0)
		else $error("enable reserved bits");
	a_dac_law: assert property (sink_dac_law == {1'b0, |sink_fade_law_sel})
		else $error("dac law mismatch");
	a_step_law: assert property (sink_step_nonlinear == sink_fade_law_sel[1])
		else $error("step law mismatch");
	a_dim_idle: assert property ((clk_en && !dim_request) [*4] |-> backlight_code == 7'h00)
		else $error("backlight dim without request");
	// ----------------------------------------
	// covers
	// ----------------------------------------
	c_write: cover property (pready && pwrite);
	c_error: cover property (pslverr);
	c_blink: cover property ($fell(sink_on[6]));
	c_dim: cover property (backlight_code != 7'h00);
endmodule : lsb_regs_monitor

// *** verif/lsb_regs_tb.sv ***
/* self-checking bench for lsb_regs: apb access, laws, dim, blink.
   assumes the monitor file is compiled first; tick shortened to 20 cycles. */
module lsb_regs_tb import lsb_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned TICK = 20;
	localparam logic [11:0] ADR [5] = '{12'h028, 12'h03C, 12'h040, 12'h044, 12'h02C};
	localparam logic [31:0] MSK [5] = '{32'h7F, 32'h03, 32'h7F, 32'hFF, 32'h00};
	localparam int          ONC [4] = '{0, 1, 2, 3};
	localparam int          OFC [4] = '{1, 2, 3, 1};
	localparam int          ONT [4] = '{1, 3, 4, 6};
	localparam int          OFT [4] = '{0, 3, 6, 9};
	logic        sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, dim_request = 0;
	logic        clk_en = 1;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic        pready, pslverr, er, sink_step_nonlinear;
	logic [6:0]  backlight_code, sink_on;
	logic [1:0]  sink_dac_law, sink_fade_law_sel;
	int          errors = 0, checks = 0;

	always #10 sys_clk = ~sys_clk;

	lsb_regs #(.TICK_CYC(TICK)) i_dut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .dim_request(dim_request),
		.backlight_code(backlight_code), .sink_on(sink_on), .sink_dac_law(sink_dac_law),
		.sink_step_nonlinear(sink_step_nonlinear), .sink_fade_law_sel(sink_fade_law_sel));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk

	// no wait-state count assumed; the watchdog ends a hang
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task run(input int idx, input logic lvl, output int n);
		n = 0;
		while (sink_on[idx] === lvl && n < 1000) begin
			@(posedge sys_clk);
			n++;
		end
	endtask : run

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, ADR[i], 32'h0);
			chk(rd, 32'h0);
			apb(1'b1, ADR[i], 32'hFFFF_FFFF);
			apb(1'b0, ADR[i], 32'h0);
			chk(rd, MSK[i]);
			chk(er, i == 4);
			apb(1'b1, ADR[i], 32'h0);
		end
		$display("regs done");
	endtask : t_regs

	task t_law;
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, 12'h03C, k);
			repeat (3) @(posedge sys_clk);
			chk(sink_fade_law_sel, k);
			chk(sink_dac_law, k != 0);
			chk(sink_step_nonlinear, k / 2);
		end
		$display("law done");
	endtask : t_law

	task t_dim;
		apb(1'b1, 12'h028, 32'hD5);
		dim_request <= 1'b1;
		repeat (6) @(posedge sys_clk);
		chk(backlight_code, 7'h55);
		// frozen: the dropped request must not reach the output yet
		clk_en <= 1'b0;
		dim_request <= 1'b0;
		repeat (6) @(posedge sys_clk);
		chk(backlight_code, 7'h55);
		clk_en <= 1'b1;
		repeat (6) @(posedge sys_clk);
		chk(backlight_code, 7'h00);
		$display("dim done");
	endtask : t_dim

	task t_sinks;
		for (int b = 0; b < 7; b++) begin
			apb(1'b1, 12'h040, 32'h1 << b);
			repeat (4) @(posedge sys_clk);
			chk(sink_on, 7'h1 << b);
		end
		apb(1'b1, 12'h040, 32'h7F);
		repeat (10) begin
			repeat (TICK) @(posedge sys_clk);
			chk(sink_on, 7'h7F);
		end
		apb(1'b0, 12'h080, 32'h0);
		chk(rd, 32'h7F);
		apb(1'b1, 12'h040, 32'h0);
		$display("sinks done");
	endtask : t_sinks

	task t_blink;
		int idx;
		int n;
		for (int i = 0; i < 4; i++) begin
			idx = 6 - i % 3;
			apb(1'b1, 12'h044, (ONC[i] << 6) | (OFC[i] << ((idx - 4) * 2)));
			apb(1'b1, 12'h040, 32'h1 << idx);
			repeat (3) @(posedge sys_clk);
			chk(sink_on, 7'h1 << idx);
			run(idx, 1'b1, n);
			run(idx, 1'b0, n);
			chk(n, OFT[OFC[i]] * TICK);
			run(idx, 1'b1, n);
			chk(n, ONT[ONC[i]] * TICK);
			run(idx, 1'b0, n);
			chk(n, OFT[OFC[i]] * TICK);
			apb(1'b1, 12'h040, 32'h0);
			repeat (3) @(posedge sys_clk);
			chk(sink_on, 7'h00);
		end
		$display("blink done");
	endtask : t_blink

	task final_report;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report

	initial begin
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		t_regs;
		t_law;
		t_dim;
		t_sinks;
		t_blink;
		final_report;
	end

	// whole run needs under 10,000 cycles
	initial begin
		#(20 * 40000);
		errors++;
		final_report;
	end
endmodule : lsb_regs_tb

bind lsb_regs lsb_regs_monitor #(.TICK_CYC(TICK_CYC)) i_mon (.sys_clk(sys_clk), .rstn(rstn),
	.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.dim_request(dim_request), .backlight_code(backlight_code), .sink_on(sink_on),
	.sink_dac_law(sink_dac_law), .sink_step_nonlinear(sink_step_nonlinear),
	.sink_fade_law_sel(sink_fade_law_sel));
